// ### pkg/sslld_map.svh
// offsets, field positions, reset values and timing figures of the serial loader
`ifndef SSLLD_MAP_SVH
`define SSLLD_MAP_SVH

// serial word
`define SSLLD_WORD_W        24
`define SSLLD_SEL_HI        2
`define SSLLD_SEL_LO        0

// select codes of the eight control registers
`define SSLLD_SEL_FREQ      3'h0
`define SSLLD_SEL_MODREF    3'h1
`define SSLLD_SEL_PHASE     3'h2
`define SSLLD_SEL_FUNC      3'h3
`define SSLLD_SEL_PUMP      3'h4
`define SSLLD_SEL_POWER     3'h5
`define SSLLD_SEL_OUTSEL    3'h6
`define SSLLD_SEL_TEST      3'h7

// register widths
`define SSLLD_W24           24
`define SSLLD_W16           16
`define SSLLD_W8            8

// frequency word fields
`define SSLLD_INT_HI        23
`define SSLLD_INT_LO        15
`define SSLLD_FRACTION_NUMERATOR_HI       14
`define SSLLD_FRACTION_NUMERATOR_LO       3

// bits held in a staging copy until the next frequency word is applied
`define SSLLD_MODREF_STAGED 24'hCFFFF8
`define SSLLD_PHASE_STAGED  16'h7FF8

// output select register fields
`define SSLLD_OSEL_HI       6
`define SSLLD_OSEL_LO       3
`define SSLLD_LD_WIDE_BIT   15
`define SSLLD_OSEL_LOCK     4'h6
`define SSLLD_OSEL_HIGH     4'h1

// reset values
`define SSLLD_RST_W24       24'h000000
`define SSLLD_RST_W16       16'h0000
`define SSLLD_RST_W8        8'h00

// lock detector figures
`define SSLLD_ERR_W         12
`define SSLLD_ERR_LSB_PS    100
`define SSLLD_THR_NARROW_NS 3
`define SSLLD_THR_WIDE_NS   10
`define SSLLD_THR_DROP_NS   30
`define SSLLD_LOCK_CYCLES   40
`define SSLLD_CNT_W         6

`endif

// ### pkg/sslld_pkg.sv
// types shared by the serial loader and its lock detector
`include "sslld_map.svh"

package sslld_pkg;

    typedef logic [`SSLLD_ERR_W-1:0] sslld_err_t;

    // one phase-detector cycle: enable pulse and measured error
    typedef struct packed {
        logic       tick;
        sslld_err_t err;
    } sslld_pd_s;

    // divider values loaded into the feedback path
    typedef struct packed {
        logic [`SSLLD_INT_HI-`SSLLD_INT_LO:0]   int_val;
        logic [`SSLLD_FRACTION_NUMERATOR_HI-`SSLLD_FRACTION_NUMERATOR_LO:0] fraction_numerator_val;
    } sslld_div_s;

    typedef enum logic {
        LD_HUNT,
        LD_LOCKED
    } sslld_lock_e;

endpackage : sslld_pkg

// ### hdl/sslld_lock_det.sv
// digital lock detector counting phase-detector cycles
`timescale 1ns/100ps
`default_nettype none
`include "sslld_map.svh"

module sslld_lock_det #(
    parameter int LOCK_CYCLES = `SSLLD_LOCK_CYCLES
) (
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    // phase detector and control
    input  wire sslld_pkg::sslld_pd_s pd,
    input  wire logic                 wide_thr,
    input  wire logic                 restart,
    // result
    output logic                      locked
);

    localparam sslld_pkg::sslld_err_t THR_NARROW =
        sslld_pkg::sslld_err_t'(`SSLLD_THR_NARROW_NS * 1000 / `SSLLD_ERR_LSB_PS);
    localparam sslld_pkg::sslld_err_t THR_WIDE =
        sslld_pkg::sslld_err_t'(`SSLLD_THR_WIDE_NS * 1000 / `SSLLD_ERR_LSB_PS);
    localparam sslld_pkg::sslld_err_t THR_DROP =
        sslld_pkg::sslld_err_t'(`SSLLD_THR_DROP_NS * 1000 / `SSLLD_ERR_LSB_PS);
    localparam logic [`SSLLD_CNT_W-1:0] CNT_LAST = `SSLLD_CNT_W'(LOCK_CYCLES - 1);

    sslld_pkg::sslld_lock_e   state_ff;
    sslld_pkg::sslld_lock_e   nxt_state;
    logic [`SSLLD_CNT_W-1:0]  cnt_ff;
    logic [`SSLLD_CNT_W-1:0]  nxt_cnt;
    logic                     nxt_locked;
    sslld_pkg::sslld_err_t    thr;

    // good-cycle run counter; a run shorter than the limit never locks
    always_comb begin
        thr = wide_thr ? THR_WIDE : THR_NARROW;
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        if (restart) begin
            nxt_state = sslld_pkg::LD_HUNT;
            nxt_cnt = '0;
        end else if (pd.tick) begin
            if (pd.err > THR_DROP) begin
                nxt_state = sslld_pkg::LD_HUNT;
                nxt_cnt = '0;
            end else if (pd.err < thr) begin
                if (cnt_ff == CNT_LAST) begin
                    nxt_state = sslld_pkg::LD_LOCKED;
                end else begin
                    nxt_cnt = cnt_ff + 1'b1;
                end
            end else begin
                nxt_cnt = '0;
            end
        end
        nxt_locked = (nxt_state == sslld_pkg::LD_LOCKED);
    end

    // registers only
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_ff <= sslld_pkg::LD_HUNT;
            cnt_ff <= '0;
            locked <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            locked <= nxt_locked;
        end
    end

endmodule : sslld_lock_det
`default_nettype wire

// ### hdl/sslld_top.sv
// serial programming front end with staged fields and lock indicator
`timescale 1ns/100ps
`default_nettype none
`include "sslld_map.svh"

module sslld_top #(
    parameter int LOCK_CYCLES = `SSLLD_LOCK_CYCLES
) (
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    // serial link pins
    input  wire logic                 link_clk,
    input  wire logic                 link_data,
    input  wire logic                 latch_strobe,
    // phase detector
    input  wire sslld_pkg::sslld_pd_s pd,
    // divider and loop control
    output sslld_pkg::sslld_div_s     divider,
    output logic                      fast_lock_start,
    output logic [`SSLLD_W24-1:0]     modulus_reference,
    output logic [`SSLLD_W16-1:0]     output_phase,
    output logic [`SSLLD_W16-1:0]     function_control,
    output logic [`SSLLD_W24-1:0]     pump_timeout,
    output logic [`SSLLD_W8-1:0]      power_control,
    output logic [`SSLLD_W16-1:0]     output_select,
    output logic [`SSLLD_W16-1:0]     factory_test,
    // lock indication
    output logic                      lock_detect,
    output logic                      observation_output
);

    // pin synchronisers; stage one is read only by stage two
    logic                     lclk_s1_ff;
    logic                     lclk_s2_ff;
    logic                     lclk_s3_ff;
    logic                     ldat_s1_ff;
    logic                     ldat_s2_ff;
    logic                     lstb_s1_ff;
    logic                     lstb_s2_ff;
    logic                     lstb_s3_ff;
    logic                     shift_en;
    logic                     latch_en;

    // serial word
    logic [`SSLLD_WORD_W-1:0] shift_ff;
    logic [`SSLLD_WORD_W-1:0] nxt_shift;
    logic [2:0]               sel;

    // register bank
    logic [`SSLLD_W24-1:0]    freq_ff;
    logic [`SSLLD_W24-1:0]    nxt_freq;
    logic [`SSLLD_W24-1:0]    modref_stage_ff;
    logic [`SSLLD_W24-1:0]    nxt_modref_stage;
    logic [`SSLLD_W16-1:0]    phase_stage_ff;
    logic [`SSLLD_W16-1:0]    nxt_phase_stage;
    logic [`SSLLD_W24-1:0]    nxt_modref;
    logic [`SSLLD_W16-1:0]    nxt_phase;
    logic [`SSLLD_W16-1:0]    nxt_func;
    logic [`SSLLD_W24-1:0]    nxt_pump;
    logic [`SSLLD_W8-1:0]     nxt_power;
    logic [`SSLLD_W16-1:0]    nxt_outsel;
    logic [`SSLLD_W16-1:0]    nxt_test;
    logic                     wr_freq;

    // channel apply
    logic                     pend_ff;
    logic                     nxt_pend;
    logic                     apply;
    sslld_pkg::sslld_div_s    nxt_div;
    logic                     nxt_fast;

    // lock routing
    logic                     locked;
    logic [3:0]               osel;
    logic                     nxt_obs;

    // two flops per pin plus one more for edge detection
    always_ff @(posedge core_clk) begin
        if (rst) begin
            lclk_s1_ff <= 1'b0;
            lclk_s2_ff <= 1'b0;
            lclk_s3_ff <= 1'b0;
            ldat_s1_ff <= 1'b0;
            ldat_s2_ff <= 1'b0;
            lstb_s1_ff <= 1'b0;
            lstb_s2_ff <= 1'b0;
            lstb_s3_ff <= 1'b0;
        end else begin
            lclk_s1_ff <= link_clk;
            lclk_s2_ff <= lclk_s1_ff;
            lclk_s3_ff <= lclk_s2_ff;
            ldat_s1_ff <= link_data;
            ldat_s2_ff <= ldat_s1_ff;
            lstb_s1_ff <= latch_strobe;
            lstb_s2_ff <= lstb_s1_ff;
            lstb_s3_ff <= lstb_s2_ff;
        end
    end

    // data and clock share the same delay, so data is sampled at its edge
    assign shift_en = lclk_s2_ff & ~lclk_s3_ff;
    assign latch_en = lstb_s2_ff & ~lstb_s3_ff;

    // shift in msb first; the shift register is the only state a clock alters
    always_comb begin
        nxt_shift = shift_ff;
        if (shift_en) begin
            nxt_shift = {shift_ff[`SSLLD_WORD_W-2:0], ldat_s2_ff};
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            shift_ff <= `SSLLD_RST_W24;
        end else begin
            shift_ff <= nxt_shift;
        end
    end

    // last three bits in are the select code
    assign sel = shift_ff[`SSLLD_SEL_HI:`SSLLD_SEL_LO];

    // a strobe arriving mid-shift latches whatever the word holds now
    assign wr_freq = latch_en && (sel == `SSLLD_SEL_FREQ);

    // register bank: one target per strobe, the rest hold
    always_comb begin
        nxt_freq = freq_ff;
        nxt_modref_stage = modref_stage_ff;
        nxt_phase_stage = phase_stage_ff;
        nxt_modref = modulus_reference;
        nxt_phase = output_phase;
        nxt_func = function_control;
        nxt_pump = pump_timeout;
        nxt_power = power_control;
        nxt_outsel = output_select;
        nxt_test = factory_test;
        // staged bits reach the active copy only on channel apply
        if (apply) begin
            nxt_modref = (modulus_reference & ~`SSLLD_MODREF_STAGED)
                       | (modref_stage_ff & `SSLLD_MODREF_STAGED);
            nxt_phase = (output_phase & ~`SSLLD_PHASE_STAGED)
                      | (phase_stage_ff & `SSLLD_PHASE_STAGED);
        end
        if (latch_en) begin
            if (sel == `SSLLD_SEL_FREQ) begin
                nxt_freq = shift_ff;
            end else if (sel == `SSLLD_SEL_MODREF) begin
                nxt_modref_stage = shift_ff;
                nxt_modref = (nxt_modref & `SSLLD_MODREF_STAGED)
                           | (shift_ff & ~`SSLLD_MODREF_STAGED);
            end else if (sel == `SSLLD_SEL_PHASE) begin
                nxt_phase_stage = shift_ff[`SSLLD_W16-1:0];
                nxt_phase = (nxt_phase & `SSLLD_PHASE_STAGED)
                          | (shift_ff[`SSLLD_W16-1:0] & ~`SSLLD_PHASE_STAGED);
            end else if (sel == `SSLLD_SEL_FUNC) begin
                nxt_func = shift_ff[`SSLLD_W16-1:0];
            end else if (sel == `SSLLD_SEL_PUMP) begin
                nxt_pump = shift_ff;
            end else if (sel == `SSLLD_SEL_POWER) begin
                nxt_power = shift_ff[`SSLLD_W8-1:0];
            end else if (sel == `SSLLD_SEL_OUTSEL) begin
                nxt_outsel = shift_ff[`SSLLD_W16-1:0];
            end else begin
                nxt_test = shift_ff[`SSLLD_W16-1:0];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            freq_ff <= `SSLLD_RST_W24;
            modref_stage_ff <= `SSLLD_RST_W24;
            phase_stage_ff <= `SSLLD_RST_W16;
            modulus_reference <= `SSLLD_RST_W24;
            output_phase <= `SSLLD_RST_W16;
            function_control <= `SSLLD_RST_W16;
            pump_timeout <= `SSLLD_RST_W24;
            power_control <= `SSLLD_RST_W8;
            output_select <= `SSLLD_RST_W16;
            factory_test <= `SSLLD_RST_W16;
        end else begin
            freq_ff <= nxt_freq;
            modref_stage_ff <= nxt_modref_stage;
            phase_stage_ff <= nxt_phase_stage;
            modulus_reference <= nxt_modref;
            output_phase <= nxt_phase;
            function_control <= nxt_func;
            pump_timeout <= nxt_pump;
            power_control <= nxt_power;
            output_select <= nxt_outsel;
            factory_test <= nxt_test;
        end
    end

    // pending channel waits for the next detector cycle
    assign apply = pend_ff & pd.tick;

    always_comb begin
        nxt_pend = pend_ff;
        nxt_div = divider;
        nxt_fast = 1'b0;
        // a write in the tick cycle itself waits for the following tick
        if (wr_freq) begin
            nxt_pend = 1'b1;
        end else if (apply) begin
            nxt_pend = 1'b0;
        end
        if (apply) begin
            nxt_div.int_val = freq_ff[`SSLLD_INT_HI:`SSLLD_INT_LO];
            nxt_div.fraction_numerator_val = freq_ff[`SSLLD_FRACTION_NUMERATOR_HI:`SSLLD_FRACTION_NUMERATOR_LO];
            nxt_fast = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pend_ff <= 1'b0;
            divider <= '0;
            fast_lock_start <= 1'b0;
        end else begin
            pend_ff <= nxt_pend;
            divider <= nxt_div;
            fast_lock_start <= nxt_fast;
        end
    end

    // range of integer and fraction is not checked; host keeps it legal
    sslld_lock_det #(
        .LOCK_CYCLES (LOCK_CYCLES)
    ) u_lock (
        .core_clk (core_clk),
        .rst      (rst),
        .pd       (pd),
        .wide_thr (output_select[`SSLLD_LD_WIDE_BIT]),
        .restart  (apply),
        .locked   (locked)
    );

    // route the lock flag or a fixed level to the observation pin
    assign osel = output_select[`SSLLD_OSEL_HI:`SSLLD_OSEL_LO];

    always_comb begin
        if (osel == `SSLLD_OSEL_LOCK) begin
            nxt_obs = locked;
        end else if (osel == `SSLLD_OSEL_HIGH) begin
            nxt_obs = 1'b1;
        end else begin
            nxt_obs = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            observation_output <= 1'b0;
            lock_detect <= 1'b0;
        end else begin
            observation_output <= nxt_obs;
            lock_detect <= locked;
        end
    end

endmodule : sslld_top
`default_nettype wire

// ### bench/sslld_top_properties.sv
// checker for the serial loader and lock indicator ports
`timescale 1ns/100ps
`default_nettype none
`include "sslld_map.svh"
module sslld_top_properties #(
    parameter int LOCK_CYCLES = `SSLLD_LOCK_CYCLES
) (
    // clock and reset
    input wire logic                  core_clk,
    input wire logic                  rst,
    // pins and outputs watched
    input wire logic                  latch_strobe,
    input wire sslld_pkg::sslld_pd_s  pd,
    input wire sslld_pkg::sslld_div_s divider,
    input wire logic                  fast_lock_start,
    input wire logic [23:0]           modulus_reference,
    input wire logic [15:0]           output_phase,
    input wire logic [15:0]           function_control,
    input wire logic [23:0]           pump_timeout,
    input wire logic [7:0]            power_control,
    input wire logic [15:0]           output_select,
    input wire logic [15:0]           factory_test,
    input wire logic                  lock_detect,
    input wire logic                  observation_output
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [6:0] run_ff;
    logic [6:0] nxt_run;
    logic       good;
    // good ticks in a row; an apply restarts the run, saturating so it never wraps
    always_comb begin
        good = pd.err < (output_select[15] ? 12'h064 : 12'h01E);
        nxt_run = fast_lock_start ? 7'h00 : run_ff;
        if (pd.tick) nxt_run = good ? nxt_run + {6'h00, ~&nxt_run} : 7'h00;
    end
    always_ff @(posedge core_clk) begin
        run_ff <= rst ? 7'h00 : nxt_run;
    end
    sequence s_big_err;
        pd.tick && (pd.err > 12'h12C);
    endsequence
    // async strobe, so allow a little synchroniser slack
    sequence s_strobe_seen;
        $past(latch_strobe, 3) || $past(latch_strobe, 4) || $past(latch_strobe, 5);
    endsequence
    AST_REG_ON_STROBE: assert property ($changed({function_control, pump_timeout,
        power_control, output_select, factory_test}) |-> s_strobe_seen)
        else $error("register changed without strobe");
    AST_FUNC_DECODE: assert property ($changed(function_control) |->
        function_control[2:0] == `SSLLD_SEL_FUNC) else $error("bad function decode");
    AST_PUMP_DECODE: assert property ($changed(pump_timeout) |->
        pump_timeout[2:0] == `SSLLD_SEL_PUMP) else $error("bad pump decode");
    AST_OSEL_DECODE: assert property ($changed(output_select) |->
        output_select[2:0] == `SSLLD_SEL_OUTSEL) else $error("bad select decode");
    AST_APPLY_ONLY: assert property ($changed(divider)
        || $changed(modulus_reference & `SSLLD_MODREF_STAGED)
        || $changed(output_phase & `SSLLD_PHASE_STAGED) |-> fast_lock_start)
        else $error("staged value moved without apply");
    AST_APPLY_ON_TICK: assert property ($rose(fast_lock_start) |-> $past(pd.tick))
        else $error("apply without tick");
    AST_APPLY_PULSE: assert property (fast_lock_start |=> !fast_lock_start)
        else $error("apply pulse too long");
    AST_DROP_ON_APPLY: assert property (fast_lock_start |=> !lock_detect)
        else $error("lock kept over new channel");
    AST_DROP_ON_ERR: assert property (s_big_err |-> ##2 !lock_detect)
        else $error("lock kept over large error");
    AST_LOCK_RUN: assert property ($rose(lock_detect) |-> $past(run_ff) >= LOCK_CYCLES)
        else $error("lock without full run");
    AST_OBS_ROUTE: assert property ($stable(output_select) && output_select[6:3] ==
        `SSLLD_OSEL_LOCK |-> observation_output == lock_detect) else $error("lock not routed");
    AST_OBS_HIGH: assert property ($stable(output_select) && output_select[6:3] ==
        `SSLLD_OSEL_HIGH |-> observation_output) else $error("pin not forced high");
endmodule : sslld_top_properties
bind sslld_top sslld_top_properties #(.LOCK_CYCLES(LOCK_CYCLES)) sslld_top_properties_inst (
    .core_clk(core_clk), .rst(rst), .latch_strobe(latch_strobe), .pd(pd), .divider(divider),
    .fast_lock_start(fast_lock_start), .modulus_reference(modulus_reference),
    .output_phase(output_phase), .function_control(function_control),
    .pump_timeout(pump_timeout), .power_control(power_control), .output_select(output_select),
    .factory_test(factory_test), .lock_detect(lock_detect),
    .observation_output(observation_output));
`default_nettype wire

// ### bench/sslld_host.sv
// host side of the three-wire programming link
`timescale 1ns/100ps
`default_nettype none
module sslld_host (
    // serial link pins
    output logic link_clk,
    output logic link_data,
    output logic latch_strobe
);
    // link clock stands low between frames
    initial begin
        link_clk = 1'b0;
        link_data = 1'b0;
        latch_strobe = 1'b0;
    end
    // 24 bits msb first, select code last, data moved only while the clock is low
    task automatic send(input logic [23:0] word, input logic strobe);
        // a 2 ns lead keeps every link and strobe edge clear of both core clock edges
        #2;
        for (int i = 23; i >= 0; i--) begin
            link_data = word[i];
            #62.5 link_clk = 1'b1;
            #62.5 link_clk = 1'b0;
        end
        link_data = ~word[0]; // idle data must not echo the last bit
        #62.5 latch_strobe = strobe;
        #62.5 latch_strobe = 1'b0;
    endtask : send
endmodule : sslld_host
`default_nettype wire

// ### bench/testbench.sv
// self-checking bench for the serial loader and lock indicator
`timescale 1ns/100ps
`default_nettype none
`include "sslld_map.svh"
module testbench;
    localparam int          LOCKN = 4;
    localparam logic [23:0] FW1   = {9'h12C, 12'h005, 3'h0};
    localparam logic [23:0] FW2   = {9'h01A, 12'h000, 3'h0};
    localparam logic [23:0] WTAB [3:7] = '{24'h00A5FB, 24'h5A3C4C, 24'h0000FD, 24'h00000E,
                                           24'h00C3A7};
    logic                  core_clk;
    logic                  rst;
    logic                  link_clk;
    logic                  link_data;
    logic                  latch_strobe;
    logic                  fast_lock_start;
    logic                  lock_detect;
    logic                  observation_output;
    sslld_pkg::sslld_pd_s  pd;
    sslld_pkg::sslld_div_s divider;
    logic [23:0]           modulus_reference;
    logic [23:0]           pump_timeout;
    logic [15:0]           output_phase;
    logic [15:0]           function_control;
    logic [15:0]           output_select;
    logic [15:0]           factory_test;
    logic [7:0]            power_control;
    logic [23:0]           ex [3:7];
    wire  [79:0]           regs_got = {function_control, pump_timeout, power_control,
                                       output_select, factory_test};
    int                    errors = 0;
    int                    n_checks = 0;
    int                    cycles = 0;
    int                    n_fast = 0;

    sslld_top #(.LOCK_CYCLES(LOCKN)) sslld_top_inst (
        .core_clk(core_clk), .rst(rst), .link_clk(link_clk), .link_data(link_data),
        .latch_strobe(latch_strobe), .pd(pd), .divider(divider),
        .fast_lock_start(fast_lock_start), .modulus_reference(modulus_reference),
        .output_phase(output_phase), .function_control(function_control),
        .pump_timeout(pump_timeout), .power_control(power_control),
        .output_select(output_select), .factory_test(factory_test),
        .lock_detect(lock_detect), .observation_output(observation_output));
    sslld_host sslld_host_inst (
        .link_clk(link_clk), .link_data(link_data), .latch_strobe(latch_strobe));

    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;

    // apply pulses counted here since they last one cycle only
    always @(posedge core_clk) begin
        if (fast_lock_start === 1'b1) n_fast++;
        cycles++;
        if (cycles == 20000) begin
            errors++;
            print_verdict();
        end
    end

    task automatic chk(input logic [159:0] got, input logic [159:0] exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : chk
    // write then wait out synchroniser and latch
    task automatic put(input logic [23:0] w);
        sslld_host_inst.send(w, 1'b1);
        repeat (8) @(negedge core_clk);
    endtask : put
    task automatic ticks(input int n, input logic [11:0] e);
        for (int i = 0; i < n; i++) begin
            @(negedge core_clk);
            pd = '{1'b1, e};
            @(negedge core_clk);
            pd = '{1'b0, 12'h000};
            repeat (2) @(negedge core_clk);
        end
    endtask : ticks
    function automatic logic [79:0] exp_regs();
        return {ex[3][15:0], ex[4], ex[5][7:0], ex[6][15:0], ex[7][15:0]};
    endfunction : exp_regs
    task print_verdict;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict

    initial begin
        rst = 1'b1;
        pd = '0;
        for (int s = 3; s <= 7; s++) ex[s] = 24'h000000;
        repeat (8) @(negedge core_clk);
        rst = 1'b0;
        chk({regs_got, divider, modulus_reference, output_phase, lock_detect,
             observation_output}, '0, "reset values");
        // select codes 3 to 7, others must hold
        for (int s = 3; s <= 7; s++) begin
            put(WTAB[s]);
            ex[s] = WTAB[s];
            chk(regs_got, exp_regs(), "decode");
        end
        chk(observation_output, 1'b1, "forced high");
        sslld_host_inst.send(24'h00FFFB, 1'b0);
        repeat (8) @(negedge core_clk);
        chk(regs_got, exp_regs(), "shift without strobe");
        // staged fields wait for the next channel
        put(24'hFFFFF9);
        chk(modulus_reference, 24'hFFFFF9 & ~`SSLLD_MODREF_STAGED, "staged modulus");
        put(24'h00FFFA);
        chk(output_phase, 16'hFFFA & ~`SSLLD_PHASE_STAGED, "staged phase");
        put(FW1);
        chk(divider, '0, "divider before tick");
        ticks(1, 12'h01D);
        chk({divider, modulus_reference, output_phase}, {FW1[23:3], 24'hFFFFF9, 16'hFFFA},
            "apply");
        chk(n_fast, 1, "one apply pulse");
        // lock run with a threshold hit in mid-run
        put(24'h000036);
        ticks(3, 12'h01D);
        ticks(1, 12'h01E);
        ticks(3, 12'h01D);
        chk(lock_detect, 1'b0, "run restarted");
        ticks(1, 12'h01D);
        chk({lock_detect, observation_output}, 2'b11, "locked");
        ticks(1, 12'h12C);
        chk(lock_detect, 1'b1, "lock kept at 30 ns");
        ticks(1, 12'h12D);
        chk(lock_detect, 1'b0, "drop on error");
        ticks(LOCKN, 12'h01D);
        put(FW2);
        ticks(1, 12'h01D);
        chk({lock_detect, divider}, {1'b0, FW2[23:3]}, "drop on channel");
        // wide threshold accepts what narrow refuses
        ticks(LOCKN, 12'h063);
        chk(lock_detect, 1'b0, "narrow refuses");
        put(24'h008036);
        ticks(LOCKN, 12'h063);
        chk(lock_detect, 1'b1, "wide accepts");
        put(24'h000006);
        chk(observation_output, 1'b0, "pin low");
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
